// ===== shared/laser_bias_consts.svh
// constants for the laser bias startup and trip monitor
`ifndef LASER_BIAS_CONSTS_SVH
`define LASER_BIAS_CONSTS_SVH

// register offsets
`define REG_SOFT_TX_DISABLE 8'h6E
`define REG_AUTO_BIAS_SELECT 8'h80
`define REG_SAMPLE_RATE_SELECT 8'h88
`define REG_MANUAL_BIAS_VALUE 8'hF8

// field positions and reset values
`define SAMPLE_RATE_CODE_LSB 0
`define SAMPLE_RATE_CODE_MAX 4'h9
`define SHIFT_FIELD_W 3
`define BIAS_RESET 16'h0000

// comparator schedule: eight readings, six for the power loop
`define APC_SLOTS 3'h6
`define SLOT_POWER_TRIP 3'h6
`define SLOT_BIAS_TRIP 3'h7

// monitor converter round robin
`define MON_CHANNELS 3'h6
`define MON_CH_TEMP 3'h0
`define MON_CH_SUPPLY 3'h1
`define MON_CH_FIRST_SHIFTED 3'h2

// clock and timing
`define CLK_PERIOD_NS 25
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATE_PAIR(f, r) {9'(`NS_TO_CYC(f)), 9'(`NS_TO_CYC(r))}

`define FIRST_NS_0 350
`define FIRST_NS_1 550
`define FIRST_NS_2 750
`define FIRST_NS_3 950
`define FIRST_NS_4 1350
`define FIRST_NS_5 1550
`define FIRST_NS_6 1750
`define FIRST_NS_7 2150
`define FIRST_NS_8 2950
`define FIRST_NS_9 3150
`define REP_NS_0 800
`define REP_NS_1 1200
`define REP_NS_2 1600
`define REP_NS_3 2000
`define REP_NS_4 2800
`define REP_NS_5 3200
`define REP_NS_6 3600
`define REP_NS_7 4400
`define REP_NS_8 6000
`define REP_NS_9 6400

`endif

// ===== shared/laser_bias_pkg.sv
// types for the laser bias startup and trip monitor
package laser_bias_pkg;

	typedef logic [15:0] bias_t;
	typedef logic [8:0] rate_cnt_t;

	// gray codes along the power-up path
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_WAIT_TEMP = 3'h1,
		ST_WAIT_SUPPLY = 3'h3,
		ST_STEP = 3'h2,
		ST_SEARCH = 3'h6,
		ST_TRACK = 3'h7
	} bias_state_e;

	typedef enum logic [1:0] {
		CMP_APC = 2'h0,
		CMP_POWER_TRIP = 2'h1,
		CMP_BIAS_TRIP = 2'h2
	} cmp_select_e;

	typedef struct packed {
		bias_state_e state;
		logic tempKnown;
		logic burstPrev;
		logic armed;
		rate_cnt_t sampCnt;
		logic [2:0] slot;
		logic lastAbove;
		bias_t loopBias;
		bias_t step;
		logic searchDone;
		logic powerHigh;
		logic powerLow;
		logic biasHigh;
		logic biasMax;
		logic shutLatch;
		logic modEn;
		logic biasEn;
		bias_t biasOut;
		cmp_select_e cmpSel;
		logic sampleStrobe;
		logic fault;
		logic gate;
	} ctrl_s;

	typedef struct packed {
		logic [2:0] chan;
		logic start;
		logic busy;
		logic [15:0] result;
		logic valid;
		logic [2:0] resChan;
	} mon_s;

endpackage

// ===== shared/monitor_if.sv
// link between the bias controller and the monitor sequencer
`timescale 1ns/1ps
interface monitor_if;
	logic adcStart;
	logic [2:0] adcChannel;
	logic adcDone;
	logic [15:0] adcRaw;
	logic [11:0] rightShifts;
	logic [15:0] result;
	logic resultValid;
	logic [2:0] resultChannel;

	modport seq (
		output adcStart, adcChannel, result, resultValid, resultChannel,
		input adcDone, adcRaw, rightShifts
	);
	modport ctl (
		input adcStart, adcChannel, result, resultValid, resultChannel,
		output adcDone, adcRaw, rightShifts
	);
endinterface

// ===== rtl/monitor_sequencer.sv
// round-robin monitor conversion sequencer with right shifts
`timescale 1ns/1ps
`include "laser_bias_consts.svh"
module monitor_sequencer
	import laser_bias_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	monitor_if.seq mon
);
	mon_s q;
	mon_s d;
	logic [2:0] shiftIdx;
	logic [2:0] shiftAmt;

	always_comb
	begin
		d = q;
		d.start = 1'b0;
		d.valid = 1'b0;
		shiftIdx = q.chan - `MON_CH_FIRST_SHIFTED;
		shiftAmt = 3'h0;
		// shift monitor inputs one to four
		if (q.chan >= `MON_CH_FIRST_SHIFTED)
		begin
			shiftAmt = mon.rightShifts[shiftIdx * `SHIFT_FIELD_W +: 3];
		end
		if (!q.busy)
		begin
			d.start = 1'b1;
			d.busy = 1'b1;
		end
		else if (mon.adcDone)
		begin
			d.result = mon.adcRaw >> shiftAmt;
			d.valid = 1'b1;
			d.resChan = q.chan;
			d.busy = 1'b0;
			d.chan = (q.chan == `MON_CHANNELS - 3'h1) ? 3'h0 : q.chan + 3'h1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign mon.adcStart = q.start;
	assign mon.adcChannel = q.chan;
	assign mon.result = q.result;
	assign mon.resultValid = q.valid;
	assign mon.resultChannel = q.resChan;
endmodule

// ===== rtl/laser_bias_startup_and_trip_monitor.sv
// bias startup, power loop, shared comparator schedule and trip alarms
// What this block does
// - outputs off until supply ok, temperature converted
// - optionally wait for supply above low alarm
// - step bias by startup step until exceeded
// - binary search, then single-step power loop
// - quick trips masked until search done
// - never step above ceiling during startup
// - startup step comes from host register
// - restart after disable skips temperature wait
// - manual bias code when auto select off
// - disable pin turns outputs off, restart
// - software disable acts like the pin
// - eight comparator readings, six for loop
// - power alarms follow last loop comparison
// - sampling starts on burst gate rise
// - rate code picks first delay, period
// - codes above nine act as nine
// - no trip updates while gate low
// - trip alarms hold until sample clears
// - compare bias code to ceiling each update
// - at ceiling set limit bit, clamp loop bias only (manual code is not clamped)
// - masked trips drive fault and shutdown gate
// - six monitor channels, shifts on four
`timescale 1ns/1ps
`include "laser_bias_consts.svh"
module laser_bias_startup_and_trip_monitor
	import laser_bias_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic supplyAboveOnLevel,
	input wire logic supplyLowAlarmEnable,
	input wire logic [15:0] supplyLowAlarmLevel,
	input wire logic txDisablePin,
	input wire logic softTxDisable,
	input wire logic burstGateInput,
	input wire logic comparatorAbove,
	input wire logic [15:0] startupStepCurrent,
	input wire logic [15:0] biasCeiling,
	input wire logic autoBiasSelect,
	input wire logic [15:0] manualBiasValue,
	input wire logic [7:0] sampleRateSelect,
	input wire logic [3:0] faultMask,
	input wire logic [3:0] shutdownMask,
	input wire logic shutdownGateInvert,
	input wire logic adcDone,
	input wire logic [15:0] adcRaw,
	input wire logic [11:0] rightShifts,
	output logic modulationOutputEnable,
	output logic biasOutputEnable,
	output logic [15:0] biasCode,
	output logic [1:0] comparatorSelect,
	output logic comparatorSample,
	output logic powerHighAlarm,
	output logic powerLowAlarm,
	output logic biasHighAlarm,
	output logic biasLimitStatus,
	output logic searchComplete,
	output logic faultOutput,
	output logic shutdownGateOutput,
	output logic adcStart,
	output logic [2:0] adcChannel,
	output logic [15:0] monitorResult,
	output logic monitorResultValid,
	output logic [2:0] monitorResultChannel
);
	ctrl_s q;
	ctrl_s d;
	monitor_if mon();

	logic txDisable;
	logic [3:0] rateCode;
	logic [17:0] ratePair;
	logic tick;
	logic apcTick;
	logic powerTick;
	logic biasTripTick;
	logic tempDone;
	logic supplyOk;
	logic [16:0] stepSum;
	logic [3:0] tripVec;
	bias_t halfStep;
	bias_state_e readyState;

	// rate code to first delay and period in cycles
	function automatic logic [17:0] rate_pair(input logic [3:0] code);
		logic [17:0] p;
		case (code)
			4'h0: p = `RATE_PAIR(`FIRST_NS_0, `REP_NS_0);
			4'h1: p = `RATE_PAIR(`FIRST_NS_1, `REP_NS_1);
			4'h2: p = `RATE_PAIR(`FIRST_NS_2, `REP_NS_2);
			4'h3: p = `RATE_PAIR(`FIRST_NS_3, `REP_NS_3);
			4'h4: p = `RATE_PAIR(`FIRST_NS_4, `REP_NS_4);
			4'h5: p = `RATE_PAIR(`FIRST_NS_5, `REP_NS_5);
			4'h6: p = `RATE_PAIR(`FIRST_NS_6, `REP_NS_6);
			4'h7: p = `RATE_PAIR(`FIRST_NS_7, `REP_NS_7);
			4'h8: p = `RATE_PAIR(`FIRST_NS_8, `REP_NS_8);
			default: p = `RATE_PAIR(`FIRST_NS_9, `REP_NS_9);
		endcase
		return p;
	endfunction

	monitor_sequencer u_monitor_sequencer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.mon(mon.seq)
	);

	assign mon.adcDone = adcDone;
	assign mon.adcRaw = adcRaw;
	assign mon.rightShifts = rightShifts;

	always_comb
	begin
		d = q;
		d.sampleStrobe = 1'b0;
		txDisable = txDisablePin | softTxDisable;
		rateCode = sampleRateSelect[`SAMPLE_RATE_CODE_LSB +: 4];
		if (rateCode > `SAMPLE_RATE_CODE_MAX)
			rateCode = `SAMPLE_RATE_CODE_MAX;
		ratePair = rate_pair(rateCode);
		tick = 1'b0;

		d.burstPrev = burstGateInput;
		if (!burstGateInput)
		begin
			d.armed = 1'b0;
		end
		else if (!q.burstPrev)
		begin
			d.armed = 1'b1;
			d.sampCnt = ratePair[17:9] - 9'h1;
		end
		else if (q.armed)
		begin
			if (q.sampCnt == 9'h0)
			begin
				tick = 1'b1;
				d.sampCnt = ratePair[8:0] - 9'h1;
			end
			else
			begin
				d.sampCnt = q.sampCnt - 9'h1;
			end
		end

		// eight readings, six for the loop, two for trips
		apcTick = tick && (q.slot < `APC_SLOTS);
		powerTick = tick && (q.slot == `SLOT_POWER_TRIP);
		biasTripTick = tick && (q.slot == `SLOT_BIAS_TRIP);
		if (tick)
		begin
			d.slot = q.slot + 3'h1;
			d.sampleStrobe = 1'b1;
		end
		if (d.slot < `APC_SLOTS)
			d.cmpSel = CMP_APC;
		else if (d.slot == `SLOT_POWER_TRIP)
			d.cmpSel = CMP_POWER_TRIP;
		else
			d.cmpSel = CMP_BIAS_TRIP;
		if (apcTick)
			d.lastAbove = comparatorAbove;

		tempDone = mon.resultValid && (mon.resultChannel == `MON_CH_TEMP);
		supplyOk = mon.resultValid && (mon.resultChannel == `MON_CH_SUPPLY)
			&& (mon.result > supplyLowAlarmLevel);
		readyState = supplyLowAlarmEnable ? ST_WAIT_SUPPLY : ST_STEP;
		stepSum = {1'b0, q.loopBias} + {1'b0, startupStepCurrent};
		halfStep = q.step >> 1;

		case (q.state)
			ST_OFF:
			begin
				// wait for supply above power-on level
				if (supplyAboveOnLevel && !txDisable && !q.shutLatch)
				begin
					d.state = q.tempKnown ? readyState : ST_WAIT_TEMP;
				end
			end
			ST_WAIT_TEMP:
			begin
				if (tempDone)
				begin
					d.tempKnown = 1'b1;
					d.state = readyState;
				end
			end
			ST_WAIT_SUPPLY:
			begin
				if (supplyOk)
					d.state = ST_STEP;
			end
			ST_STEP:
			begin
				if (burstGateInput && apcTick && comparatorAbove)
				begin
					d.step = startupStepCurrent >> 1;
					d.loopBias = q.loopBias - (startupStepCurrent >> 1);
					d.state = ST_SEARCH;
				end
				else if (burstGateInput
					&& (q.loopBias == `BIAS_RESET || apcTick))
				begin
					// ceiling reached, search instead of step
					if (stepSum > {1'b0, biasCeiling})
					begin
						d.step = startupStepCurrent >> 1;
						d.state = ST_SEARCH;
					end
					else
					begin
						d.loopBias = stepSum[15:0];
					end
				end
			end
			ST_SEARCH:
			begin
				if (q.step == `BIAS_RESET)
				begin
					d.searchDone = 1'b1;
					d.state = ST_TRACK;
				end
				else if (apcTick)
				begin
					d.step = halfStep;
					if (comparatorAbove)
					begin
						d.loopBias = (q.loopBias > q.step)
							? q.loopBias - q.step : `BIAS_RESET;
					end
					// a step past the ceiling is not taken
					else if ({1'b0, q.loopBias} + {1'b0, q.step}
						<= {1'b0, biasCeiling})
					begin
						d.loopBias = q.loopBias + q.step;
					end
				end
			end
			ST_TRACK:
			begin
				if (apcTick)
				begin
					if (comparatorAbove && q.loopBias != `BIAS_RESET)
						d.loopBias = q.loopBias - 16'h0001;
					else if (!comparatorAbove && q.loopBias < biasCeiling)
						d.loopBias = q.loopBias + 16'h0001;
				end
			end
			default:
			begin
				d.state = ST_OFF;
			end
		endcase

		if (d.loopBias > biasCeiling)
			d.loopBias = biasCeiling;

		// trips only update with gate high
		// alarms hold until a later sample
		if (q.searchDone)
		begin
			// power alarms follow last loop comparison
			if (powerTick)
			begin
				d.powerHigh = q.lastAbove;
				d.powerLow = !q.lastAbove;
			end
			if (biasTripTick)
				d.biasHigh = comparatorAbove;
		end
		else
		begin
			d.powerHigh = 1'b0;
			d.powerLow = 1'b0;
			d.biasHigh = 1'b0;
		end

		if (txDisable)
			d.shutLatch = 1'b0;
		if (!supplyAboveOnLevel)
			d.tempKnown = 1'b0;
		if (!supplyAboveOnLevel || txDisable || q.shutLatch)
		begin
			d.state = ST_OFF;
			d.loopBias = `BIAS_RESET;
			d.step = `BIAS_RESET;
			d.searchDone = 1'b0;
			d.powerHigh = 1'b0;
			d.powerLow = 1'b0;
			d.biasHigh = 1'b0;
		end

		d.modEn = (d.state == ST_STEP) || (d.state == ST_SEARCH)
			|| (d.state == ST_TRACK);
		d.biasEn = d.modEn;
		// manual bias code when auto select is off
		if (!d.modEn)
			d.biasOut = `BIAS_RESET;
		else if (autoBiasSelect)
			d.biasOut = d.loopBias;
		else
			d.biasOut = manualBiasValue;
		// digital ceiling compare on every update
		// ceiling compare stays live through startup
		d.biasMax = d.modEn && (d.biasOut >= biasCeiling);

		// masked trips to fault and shutdown gate
		tripVec = {d.biasMax, d.biasHigh, d.powerLow, d.powerHigh};
		d.fault = |(tripVec & faultMask);
		// the disable clear wins, since a disable zeroes every trip in the same cycle
		if (|(tripVec & shutdownMask))
			d.shutLatch = 1'b1;
		d.gate = d.shutLatch ^ shutdownGateInvert;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign modulationOutputEnable = q.modEn;
	assign biasOutputEnable = q.biasEn;
	assign biasCode = q.biasOut;
	assign comparatorSelect = q.cmpSel;
	assign comparatorSample = q.sampleStrobe;
	assign powerHighAlarm = q.powerHigh;
	assign powerLowAlarm = q.powerLow;
	assign biasHighAlarm = q.biasHigh;
	assign biasLimitStatus = q.biasMax;
	assign searchComplete = q.searchDone;
	assign faultOutput = q.fault;
	assign shutdownGateOutput = q.gate;
	assign adcStart = mon.adcStart;
	assign adcChannel = mon.adcChannel;
	assign monitorResult = mon.result;
	assign monitorResultValid = mon.resultValid;
	assign monitorResultChannel = mon.resultChannel;
endmodule

// ===== tb/laser_bias_asserts.sv
// port assertions for the bias startup and trip monitor
`timescale 1ns/1ps
module laser_bias_asserts
	import laser_bias_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic supplyAboveOnLevel,
	input wire logic txDisablePin,
	input wire logic softTxDisable,
	input wire logic burstGateInput,
	input wire logic [15:0] biasCeiling,
	input wire logic autoBiasSelect,
	input wire logic [15:0] manualBiasValue,
	input wire logic [7:0] sampleRateSelect,
	input wire logic adcDone,
	input wire logic [15:0] adcRaw,
	input wire logic [11:0] rightShifts,
	input wire logic modulationOutputEnable,
	input wire logic biasOutputEnable,
	input wire logic [15:0] biasCode,
	input wire logic comparatorSample,
	input wire logic powerHighAlarm,
	input wire logic powerLowAlarm,
	input wire logic biasHighAlarm,
	input wire logic searchComplete,
	input wire logic adcStart,
	input wire logic [15:0] monitorResult,
	input wire logic monitorResultValid,
	input wire logic [2:0] monitorResultChannel
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence gateRiseFast;
		$rose(burstGateInput) && sampleRateSelect[3:0] == 4'h0;
	endsequence
	// the +-2 slack covers where the gate edge lands in the cycle
	sequence firstSample;
		!comparatorSample [*8] ##[5:9] comparatorSample;
	endsequence
	first_sample_a: assert property (
		gateRiseFast |-> burstGateInput throughout firstSample)
		else $error("first comparator sample off time");
	sample_pulse_a: assert property (
		comparatorSample |=> !comparatorSample)
		else $error("comparator sample longer than one cycle");
	disable_off_a: assert property (
		txDisablePin || softTxDisable |-> ##[1:2]
		!modulationOutputEnable && !biasOutputEnable)
		else $error("outputs not off after disable");
	supply_off_a: assert property (
		!supplyAboveOnLevel |-> ##[1:2] !modulationOutputEnable)
		else $error("outputs on with supply low");
	ceiling_a: assert property (
		autoBiasSelect && $past(autoBiasSelect, 2) && $stable(biasCeiling)
		&& $past(biasCeiling, 2) == biasCeiling |-> biasCode <= biasCeiling)
		else $error("bias above ceiling");
	trips_masked_a: assert property (
		!searchComplete ##1 !searchComplete
		|-> !powerHighAlarm && !powerLowAlarm && !biasHighAlarm)
		else $error("trip alarm before search done");
	gate_low_hold_a: assert property (
		!burstGateInput [*3] ##0 modulationOutputEnable
		|-> $stable({powerHighAlarm, powerLowAlarm, biasHighAlarm}))
		else $error("trip alarm changed while gate low");
	manual_bias_a: assert property (
		!autoBiasSelect && !$past(autoBiasSelect) && biasOutputEnable
		&& !$past(autoBiasSelect, 2) && $stable(manualBiasValue)
		|-> biasCode == manualBiasValue)
		else $error("manual bias not on output");
	shift_a: assert property (
		monitorResultValid && monitorResultChannel == 3'h2
		|-> monitorResult == $past(adcRaw) >> rightShifts[2:0])
		else $error("monitor one result not shifted");
	adc_answer_a: assert property (
		adcDone |=> monitorResultValid ##[0:1] adcStart)
		else $error("conversion result or next start missing");
endmodule

// ===== tb/laser_driver_model.sv
// laser driver, monitor photodiode and monitor converter model
`timescale 1ns/1ps
module laser_driver_model
	import laser_bias_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slowAdc,
	input wire logic [15:0] powerTarget,
	input wire logic [15:0] biasCode,
	input wire logic biasOutputEnable,
	input wire logic [1:0] comparatorSelect,
	input wire logic adcStart,
	input wire logic [2:0] adcChannel,
	output logic comparatorAbove,
	output logic adcDone,
	output logic [15:0] adcRaw
);
	logic [4:0] waitCnt;
	logic busy;
	logic [2:0] chan;
	// photodiode feedback grows with bias; bias trip watches a fixed level
	always_comb
	begin
		if (comparatorSelect == 2'h2)
			comparatorAbove = biasCode > 16'hFF00;
		else
			comparatorAbove = biasOutputEnable && biasCode > powerTarget;
	end
	// raw data toggles outside the done cycle so stale values never match
	always_ff @(posedge ref_clk)
	begin
		adcDone <= 1'b0;
		adcRaw <= ~adcRaw;
		if (sys_rst)
		begin
			busy <= 1'b0;
			adcRaw <= 16'h0000;
		end
		else if (adcStart)
		begin
			busy <= 1'b1;
			chan <= adcChannel;
			waitCnt <= slowAdc ? 5'h14 : 5'h02;
		end
		else if (busy && waitCnt == 5'h00)
		begin
			busy <= 1'b0;
			adcDone <= 1'b1;
			adcRaw <= chan == 3'h0 ? 16'h1900 : chan == 3'h1 ? 16'h8000
				: 16'hA5C0 | 16'(chan);
		end
		else if (busy)
			waitCnt <= waitCnt - 5'h01;
	end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the bias startup and trip monitor
`timescale 1ns/1ps
module testbench
	import laser_bias_pkg::*;
;
	logic ref_clk, sys_rst, supplyAboveOnLevel, supplyLowAlarmEnable;
	logic txDisablePin, softTxDisable, burstGateInput, comparatorAbove;
	logic autoBiasSelect, shutdownGateInvert, adcDone, slowAdc, adcStart;
	logic [15:0] supplyLowAlarmLevel, startupStepCurrent, biasCeiling;
	logic [15:0] manualBiasValue, adcRaw, biasCode, monitorResult, powerTarget;
	logic [15:0] e;
	logic [7:0] sampleRateSelect;
	logic [3:0] faultMask, shutdownMask;
	logic [11:0] rightShifts;
	logic [1:0] comparatorSelect;
	logic [2:0] adcChannel, monitorResultChannel, prevCh;
	logic modulationOutputEnable, biasOutputEnable, comparatorSample;
	logic powerHighAlarm, powerLowAlarm, biasHighAlarm, biasLimitStatus;
	logic searchComplete, faultOutput, shutdownGateOutput, monitorResultValid;
	int n_fail, tests_run, cycles, n, t, k;
	int firstNs[10] = '{350, 550, 750, 950, 1350, 1550, 1750, 2150, 2950, 3150};
	int repNs[10] = '{800, 1200, 1600, 2000, 2800, 3200, 3600, 4400, 6000, 6400};
	laser_bias_startup_and_trip_monitor u_laser_bias_startup_and_trip_monitor
		(.*);
	laser_driver_model u_laser_driver_model (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_fail++;
			$display("ERROR run length expected 40000 seen %0d", cycles);
			stop_test();
		end
	end
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// settle past the edge, then poll under a bound
	task automatic wait_for(ref logic sig, input int lim);
		n = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		while (sig !== 1'b1 && n < lim);
	endtask
	// callers drive on the edge; this lets outputs settle before a compare
	task automatic hold(input int after);
		repeat (after) @(posedge ref_clk);
		#1;
	endtask
	task automatic burst(input logic [7:0] code, input int c);
		@(posedge ref_clk);
		burstGateInput <= 1'b0;
		sampleRateSelect <= code;
		repeat (4) @(posedge ref_clk);
		burstGateInput <= 1'b1;
		wait_for(comparatorSample, 400);
		t = (firstNs[c] + 24) / 25;
		tests_run++;
		if (n < t || n > t + 3)
		begin
			n_fail++;
			$display("ERROR first sample expected %0d seen %0d", t + 1, n);
		end
		wait_for(comparatorSample, 400);
		check("sample period", 16'((repNs[c] + 24) / 25), 16'(n));
	endtask
	initial
	begin
		{sys_rst, supplyLowAlarmEnable, autoBiasSelect} = 3'h7;
		{supplyAboveOnLevel, txDisablePin, softTxDisable} = 3'h0;
		{burstGateInput, shutdownGateInvert, slowAdc} = 3'h0;
		supplyLowAlarmLevel = 16'hFFF0;
		startupStepCurrent = 16'h0100;
		biasCeiling = 16'hF000;
		manualBiasValue = 16'h0321;
		powerTarget = 16'h0A40;
		sampleRateSelect = 8'h00;
		{faultMask, shutdownMask} = 8'h00;
		rightShifts = 12'h1EB;
		{n_fail, tests_run, cycles} = 0;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		hold(300);
		check("modulation before supply", 16'h0, 16'(modulationOutputEnable));
		@(posedge ref_clk) supplyAboveOnLevel <= 1'b1;
		hold(300);
		check("modulation supply low", 16'h0, 16'(modulationOutputEnable));
		@(posedge ref_clk) supplyLowAlarmLevel <= 16'h7000;
		wait_for(modulationOutputEnable, 400);
		check("modulation after power-up", 16'h1, 16'(modulationOutputEnable));
		check("bias with gate low", 16'h0, biasCode);
		@(posedge ref_clk) burstGateInput <= 1'b1;
		hold(4);
		check("first bias step", startupStepCurrent, biasCode);
		wait_for(searchComplete, 5000);
		repeat (400) @(posedge ref_clk);
		#1;
		check("search complete", 16'h1, 16'(searchComplete));
		check("bias near set point", powerTarget, biasCode & 16'hFFFE);
		@(posedge ref_clk) autoBiasSelect <= 1'b0;
		hold(4);
		check("manual bias", manualBiasValue, biasCode);
		@(posedge ref_clk) autoBiasSelect <= 1'b1;
		hold(2);
		for (k = 0; k < 16; k++)
			burst({4'hA, 4'(k)}, k > 9 ? 9 : k);
		@(posedge ref_clk) txDisablePin <= 1'b1;
		hold(3);
		check("bias off on disable", 16'h0, biasCode);
		// fastest rate keeps the clamped restart short
		@(posedge ref_clk) txDisablePin <= 1'b0;
		biasCeiling <= 16'h0500;
		faultMask <= 4'h8;
		sampleRateSelect <= 8'h00;
		wait_for(searchComplete, 5000);
		repeat (400) @(posedge ref_clk);
		#1;
		check("bias clamped", 16'h0500, biasCode);
		check("limit status", 16'h1, 16'(biasLimitStatus));
		check("fault output", 16'h1, 16'(faultOutput));
		check("power low alarm", 16'h1, 16'(powerLowAlarm));
		check("power high alarm", 16'h0, 16'(powerHighAlarm));
		@(posedge ref_clk) shutdownMask[3] <= 1'b1;
		shutdownGateInvert <= 1'b1;
		hold(5);
		check("gate latched", 16'h0, 16'(shutdownGateOutput));
		check("shut modulation", 16'h0, 16'(modulationOutputEnable));
		@(posedge ref_clk) softTxDisable <= 1'b1;
		shutdownMask <= 4'h0;
		hold(4);
		check("gate cleared", 16'h1, 16'(shutdownGateOutput));
		@(posedge ref_clk) softTxDisable <= 1'b0;
		wait_for(modulationOutputEnable, 400);
		check("restart modulation", 16'h1, 16'(modulationOutputEnable));
		@(posedge ref_clk) slowAdc <= 1'b1;
		wait_for(monitorResultValid, 200);
		for (k = 0; k < 7; k++)
		begin
			prevCh = monitorResultChannel;
			wait_for(monitorResultValid, 200);
			t = int'(monitorResultChannel);
			e = t == 0 ? 16'h1900 : t == 1 ? 16'h8000
				: (16'hA5C0 | 16'(t)) >> ((rightShifts >> (3 * (t - 2))) & 12'h7);
			check("monitor channel", prevCh == 3'h5 ? 16'h0 : 16'(prevCh) + 16'h1,
				16'(monitorResultChannel));
			check("monitor result", e, monitorResult);
		end
		stop_test();
	end
endmodule
bind laser_bias_startup_and_trip_monitor laser_bias_asserts
	u_laser_bias_asserts (.*);
